// *** verilog/absc_pkg.sv ***
/*
  Shared constants and types of the analog board status and code-select block:
  timing, register map, field positions, display glyphs, board states.
  Assumes a single 40 MHz system clock.
*/
package absc_pkg;

  // clock and times
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int POWERUP_MS = 5000;
  localparam int POWERUP_CYC = POWERUP_MS * CYC_PER_MS;
  localparam int PWM_PERIOD_US = 1000;
  localparam int PWM_CYC = PWM_PERIOD_US * CYC_PER_US;
  localparam int FAST_HALF_MS = 125;
  localparam int FAST_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int SLOW_HALF_MS = 500;
  localparam int SLOW_CYC = SLOW_HALF_MS * CYC_PER_MS;
  // cycles after reset before the switches are sampled; covers the synchroniser
  localparam int SETTLE_CYC = 16;

  // package code
  localparam int CODE_W = 6;
  localparam logic [63:0] VALID_CODES_DEF = 64'h7FFF_FFFF_FFFF_FFFE;
  localparam logic [5:0] DEC_BASE = 6'h0A;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DISP = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INT_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;

  // status register fields
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_SAMPLED = 6;
  localparam int STAT_WRONG = 7;
  localparam int STAT_JUMPER = 8;
  localparam int STAT_BRIDGE = 9;
  localparam int STAT_FULL = 10;
  localparam int STAT_LEVEL_LSB = 11;

  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_SAMPLED = 0;
  localparam int IRQ_WRONG = 1;
  localparam int IRQ_LEVEL = 2;

  // feedback duty in quarters of the period
  typedef enum logic [2:0] {
    DUTY_0   = 3'h0,
    DUTY_25  = 3'h1,
    DUTY_50  = 3'h2,
    DUTY_75  = 3'h3,
    DUTY_100 = 3'h4
  } absc_duty_t;

  // board state as written by firmware
  typedef enum logic [2:0] {
    BS_ERROR      = 3'h0,
    BS_STANDBY    = 3'h1,
    BS_SPEED_DROP = 3'h2,
    BS_RUN        = 3'h3,
    BS_HEAT       = 3'h4
  } absc_state_t;

  typedef enum logic [1:0] {
    PH_SETTLE = 2'h0,
    PH_SHOW   = 2'h1,
    PH_RUN    = 2'h2
  } absc_phase_t;

  // display glyph codes, one nibble per digit, leftmost digit in the top nibble
  localparam logic [3:0] GLYPH_0 = 4'h0;
  localparam logic [3:0] GLYPH_DASH = 4'hA;
  localparam logic [3:0] GLYPH_C = 4'hC;
  localparam logic [3:0] GLYPH_E = 4'hE;
  localparam logic [15:0] DISP_WRONG_CODE = {GLYPH_E, GLYPH_DASH, 4'h3, 4'h9};
  localparam logic [15:0] DISP_RESET = 16'hAAAA;

endpackage

// *** verilog/absc_sync.sv ***
/*
  Pin synchroniser: three flops, and a new value is accepted once the second
  and third agree. Assumes asynchronous pins and a free-running clock.
*/
`timescale 1ns/100ps
module absc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins and their clean copy
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1, s2, s3, next_dout;

  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule // absc_sync

// *** verilog/absc_pwm.sv ***
/*
  Feedback PWM generator with a fixed period; the duty level is taken only
  at the period boundary. Assumes level comes from logic on the same clock.
*/
`timescale 1ns/100ps
module absc_pwm
  import absc_pkg::*;
#(
  parameter int PERIOD = PWM_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // duty in quarters and output
  input wire absc_pkg::absc_duty_t level,
  output logic pwm_out
);
  logic [31:0] cnt, next_cnt, thr;
  absc_duty_t level_q, next_level_q;
  logic next_pwm_out;

  if (PERIOD < 4) begin : g_chk
    $error("absc_pwm: PERIOD too small");
  end

  always_comb begin
    next_cnt = cnt + 32'h1;
    next_level_q = level_q;
    if (cnt == 32'(PERIOD - 1)) begin
      next_cnt = '0;
      next_level_q = level;
    end
    // threshold follows the level of the period being started, so its first
    // cycle never carries the old duty
    case (next_level_q)
      DUTY_0: thr = '0;
      DUTY_25: thr = 32'(PERIOD / 4);
      DUTY_50: thr = 32'(PERIOD / 2);
      DUTY_75: thr = 32'((PERIOD / 4) * 3);
      DUTY_100: thr = 32'(PERIOD);
      default: thr = '0;
    endcase
    next_pwm_out = next_cnt < thr;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      level_q <= DUTY_0;
      pwm_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level_q <= next_level_q;
      pwm_out <= next_pwm_out;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  level_boundary_a: assert property (
    cnt != 32'(PERIOD - 1) |=> $stable(level_q))
    else $error("duty level changed inside a period");
  full_duty_a: assert property (
    (level_q == DUTY_100 && cnt != 32'(PERIOD - 1)) |=> pwm_out)
    else $error("full duty output went low");
endmodule // absc_pwm

// *** verilog/absc_board.sv ***
/*
  Analog board status and code select: samples the package switches once
  after reset, latches a wrong-code fault, encodes board state on the
  feedback PWM, drives the status LED, display code and speed-range select,
  and offers an APB register file with a level interrupt.
  Assumes firmware writes the board state and the display word over APB,
  and that switches, jumper and bridge arrive as asynchronous pins.
*/
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps

module absc_board
  import absc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int PWM_CYCLES = PWM_CYC,
  parameter int FAST_CYCLES = FAST_CYC,
  parameter int SLOW_CYCLES = SLOW_CYC,
  parameter logic [63:0] VALID_CODES = VALID_CODES_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // board pins
  input wire logic [1:6] SWITCH,
  input wire logic FB_JUMPER,
  input wire logic RANGE_BRIDGE,
  // board outputs
  output logic FEEDBACK_PWM,
  output logic STATUS_LED,
  output logic [15:0] DISP_CODE,
  output logic FULL_RANGE,
  output logic IRQ
);
  if (POWERUP_CYCLES < 1 || FAST_CYCLES < 1 || SLOW_CYCLES < 1) begin : g_chk
    $error("absc_board: timing counts must be positive");
  end

  logic [CODE_W+1:0] pins;
  logic [CODE_W-1:0] switch_s;
  logic jumper, bridge;

  // switch 1 sits at the top of the pin vector
  absc_sync #(.W(CODE_W + 2)) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .din({SWITCH, FB_JUMPER, RANGE_BRIDGE}),
    .dout(pins)
  );
  // the code weights run left to right: switch 1 is the lsb, switch 6 the msb
  always_comb begin
    for (int i = 0; i < CODE_W; i++) begin
      switch_s[i] = pins[CODE_W + 1 - i];
    end
  end
  assign jumper = pins[1];
  assign bridge = pins[0];

  // power-up sequence and one-time code capture
  absc_phase_t phase, next_phase;
  logic [31:0] tmr, next_tmr;
  logic [CODE_W-1:0] pkg_code, next_pkg_code;
  logic wrong_code, next_wrong_code;
  logic sample_now;

  always_comb begin
    next_phase = phase;
    next_tmr = tmr + 32'h1;
    next_pkg_code = pkg_code;
    next_wrong_code = wrong_code;
    sample_now = 1'b0;
    case (phase)
      PH_SETTLE: begin
        if (tmr == 32'(SETTLE_CYC - 1)) begin
          sample_now = 1'b1;
          next_pkg_code = switch_s;
          next_wrong_code = !VALID_CODES[switch_s];
          next_phase = PH_SHOW;
          next_tmr = '0;
        end
      end
      PH_SHOW: begin
        if (tmr == 32'(POWERUP_CYCLES - 1)) begin
          next_phase = PH_RUN;
          next_tmr = '0;
        end
      end
      PH_RUN: begin
        // sampling never happens again until reset
        next_tmr = '0;
      end
      default: begin
        next_phase = PH_SETTLE;
        next_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase <= PH_SETTLE;
      tmr <= '0;
      pkg_code <= '0;
      wrong_code <= 1'b0;
    end else begin
      phase <= next_phase;
      tmr <= next_tmr;
      pkg_code <= next_pkg_code;
      wrong_code <= next_wrong_code;
    end
  end

  // registers written by firmware
  absc_state_t ctrl_state, next_ctrl_state;
  logic [15:0] disp_word, next_disp_word;
  logic [IRQ_W-1:0] int_stat, next_int_stat, int_en, next_int_en, int_clr, ev;
  logic [31:0] next_prdata, status;
  logic next_pready, next_pslverr, access, hit;

  // derived board behaviour
  absc_duty_t lvl, next_lvl;
  logic fault, running, next_led, next_full, next_irq;
  logic [31:0] lcnt, next_lcnt;
  logic [15:0] next_disp;
  logic [CODE_W-1:0] tens, ones;

  always_comb begin
    fault = wrong_code || ctrl_state == BS_ERROR;
    running = ctrl_state == BS_RUN || ctrl_state == BS_HEAT;
    // feedback duty
    if (!jumper) begin
      next_lvl = fault ? DUTY_0 : DUTY_100;
    end else if (wrong_code) begin
      next_lvl = DUTY_25;
    end else begin
      case (ctrl_state)
        BS_ERROR: next_lvl = DUTY_0;
        BS_STANDBY: next_lvl = DUTY_50;
        BS_SPEED_DROP: next_lvl = DUTY_75;
        BS_RUN: next_lvl = DUTY_100;
        BS_HEAT: next_lvl = DUTY_100;
        default: next_lvl = DUTY_0;
      endcase
    end
    // status led: one counter serves both flash rates
    next_lcnt = lcnt + 32'h1;
    next_led = STATUS_LED;
    if ((running || ctrl_state == BS_SPEED_DROP) && !fault) begin
      next_lcnt = '0;
      next_led = 1'b1;
    end else if (lcnt >= 32'(fault ? FAST_CYCLES - 1 : SLOW_CYCLES - 1)) begin
      next_lcnt = '0;
      next_led = !STATUS_LED;
    end
    // display: a wrong-code fault beats the power-up code, firmware owns the rest
    tens = pkg_code / DEC_BASE;
    ones = pkg_code % DEC_BASE;
    if (wrong_code) begin
      next_disp = DISP_WRONG_CODE;
    end else if (phase == PH_SHOW) begin
      next_disp = {GLYPH_C, GLYPH_0, tens[3:0], ones[3:0]};
    end else begin
      next_disp = disp_word;
    end
    // limited range in speed-drop protection whatever the bridge says
    next_full = bridge && ctrl_state != BS_SPEED_DROP;
  end

  // apb slave: one wait state, so every access phase is two cycles
  always_comb begin
    access = PSEL && PENABLE && !PREADY;
    next_pready = access;
    next_pslverr = 1'b0;
    next_prdata = '0;
    next_ctrl_state = ctrl_state;
    next_disp_word = disp_word;
    next_int_en = int_en;
    int_clr = '0;
    hit = 1'b1;
    status = '0;
    status[STAT_CODE_LSB +: CODE_W] = pkg_code;
    status[STAT_SAMPLED] = phase != PH_SETTLE;
    status[STAT_WRONG] = wrong_code;
    status[STAT_JUMPER] = jumper;
    status[STAT_BRIDGE] = bridge;
    status[STAT_FULL] = FULL_RANGE;
    status[STAT_LEVEL_LSB +: 3] = lvl;
    case (PADDR)
      ADDR_CTRL: next_prdata = 32'(ctrl_state);
      ADDR_STATUS: next_prdata = status;
      ADDR_DISP: next_prdata = 32'(disp_word);
      ADDR_INT_STATUS: next_prdata = 32'(int_stat);
      ADDR_INT_CLEAR: next_prdata = '0;
      ADDR_INT_ENABLE: next_prdata = 32'(int_en);
      default: hit = 1'b0;
    endcase
    if (access) begin
      next_pslverr = !hit;
      if (PWRITE) begin
        next_prdata = '0;
        case (PADDR)
          ADDR_CTRL: next_ctrl_state = absc_state_t'(PWDATA[2:0]);
          ADDR_DISP: next_disp_word = PWDATA[15:0];
          ADDR_INT_CLEAR: int_clr = PWDATA[IRQ_W-1:0];
          ADDR_INT_ENABLE: next_int_en = PWDATA[IRQ_W-1:0];
          default: next_ctrl_state = ctrl_state;
        endcase
      end
    end else begin
      next_prdata = '0;
    end
    // events: set wins over a clear in the same cycle
    ev = '0;
    ev[IRQ_SAMPLED] = sample_now;
    ev[IRQ_WRONG] = sample_now && next_wrong_code;
    // pins are still settling after reset, so a level change then is no event
    ev[IRQ_LEVEL] = next_lvl != lvl && phase != PH_SETTLE;
    next_int_stat = (int_stat & ~int_clr) | ev;
    next_irq = |(int_stat & int_en);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_state <= BS_STANDBY;
      disp_word <= DISP_RESET;
      int_stat <= '0;
      int_en <= '0;
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      lvl <= DUTY_50;
      lcnt <= '0;
      STATUS_LED <= 1'b0;
      DISP_CODE <= DISP_RESET;
      FULL_RANGE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      ctrl_state <= next_ctrl_state;
      disp_word <= next_disp_word;
      int_stat <= next_int_stat;
      int_en <= next_int_en;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      lvl <= next_lvl;
      lcnt <= next_lcnt;
      STATUS_LED <= next_led;
      DISP_CODE <= next_disp;
      FULL_RANGE <= next_full;
      IRQ <= next_irq;
    end
  end

  // the pwm stage latches lvl only at its period boundary
  absc_pwm #(.PERIOD(PWM_CYCLES)) u_pwm (
    .clk(CLK),
    .resetn(RESETN),
    .level(lvl),
    .pwm_out(FEEDBACK_PWM)
  );

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence sample_edge_s;
    phase == PH_SETTLE && tmr == 32'(SETTLE_CYC - 1);
  endsequence
  sequence apb_access_s;
    PSEL && PENABLE && !PREADY;
  endsequence

  code_capture_a: assert property (sample_edge_s |=> pkg_code == $past(switch_s))
    else $error("package code differs from sampled switches");
  code_hold_a: assert property (phase != PH_SETTLE |=> $stable(pkg_code))
    else $error("package code changed after sampling");
  fault_latch_a: assert property (wrong_code |=> wrong_code)
    else $error("wrong-code fault cleared without reset");
  wrong_disp_a: assert property (wrong_code |=> DISP_CODE == DISP_WRONG_CODE)
    else $error("wrong-code fault not shown on display");
  wrong_duty_a: assert property ((jumper && wrong_code) |=> lvl == DUTY_25)
    else $error("wrong-code duty is not 25 percent");
  plain_duty_a: assert property ((!jumper && !fault) |=> lvl == DUTY_100)
    else $error("plain feedback not full duty when ok");
  powerup_disp_a: assert property ((phase == PH_SHOW && !wrong_code) |=> DISP_CODE[15:12] == GLYPH_C)
    else $error("power-up display not showing package code");
  run_led_a: assert property ((running && !fault)[*2] |-> STATUS_LED)
    else $error("status led not steady while running");
  drop_range_a: assert property (ctrl_state == BS_SPEED_DROP |=> !FULL_RANGE)
    else $error("full range during speed-drop protection");
  bridge_range_a: assert property ((bridge && running) |=> FULL_RANGE)
    else $error("bridge fitted but limited range selected");
  apb_answer_a: assert property (apb_access_s |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle after access");
  irq_level_a: assert property (|(int_stat & int_en) |=> IRQ)
    else $error("interrupt not raised for enabled status bit");
endmodule // absc_board

// *** verif/absc_ctrl_model.sv ***
/*
  Model of the external system controller that reads the feedback PWM.
  On a request it counts high samples over one full period and reports
  the duty in quarters. Assumes the period matches the board's PWM.
*/
`timescale 1ns/100ps
module absc_ctrl_model #(
  parameter int PERIOD = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // feedback input and measurement
  input wire logic fb,
  input wire logic req,
  output logic done,
  output logic [2:0] quarters
);
  int cnt;
  int hi;
  logic busy;

  // any window of one full period holds the same number of high samples,
  // so the controller needs no knowledge of the board's period phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 0;
      hi <= 0;
      done <= 1'b0;
      quarters <= 3'h0;
    end else begin
      done <= 1'b0;
      if (req && !busy) begin
        busy <= 1'b1;
        cnt <= 0;
        hi <= 0;
      end else if (busy) begin
        hi <= hi + (fb ? 1 : 0);
        cnt <= cnt + 1;
        if (cnt == PERIOD - 1) begin
          busy <= 1'b0;
          done <= 1'b1;
          quarters <= 3'((hi + (fb ? 1 : 0)) * 4 / PERIOD);
        end
      end
    end
  end
endmodule // absc_ctrl_model

// *** verif/testbench.sv ***
/*
  Self-checking bench of the board status block: APB master, pin stimulus,
  controller model on the feedback PWM, queue-based result checking.
  Assumes the short timing parameters set at the instance below.
*/
`timescale 1ns/100ps
module testbench;
  import absc_pkg::*;
  localparam int PWM = 8;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, FB_JUMPER, RANGE_BRIDGE, FEEDBACK_PWM;
  logic PREADY, PSLVERR, STATUS_LED, FULL_RANGE, IRQ, req, done;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [1:6] SWITCH;
  logic [15:0] DISP_CODE;
  logic [2:0] quarters;
  logic [5:0] code;
  logic [32:0] exp_rd[$];
  logic [2:0] exp_duty[$];
  int error_cnt, checks, cyc, t;

  absc_board #(.POWERUP_CYCLES(50), .PWM_CYCLES(PWM), .FAST_CYCLES(3), .SLOW_CYCLES(7)) uut (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SWITCH(SWITCH), .FB_JUMPER(FB_JUMPER), .RANGE_BRIDGE(RANGE_BRIDGE),
    .FEEDBACK_PWM(FEEDBACK_PWM), .STATUS_LED(STATUS_LED), .DISP_CODE(DISP_CODE),
    .FULL_RANGE(FULL_RANGE), .IRQ(IRQ));
  absc_ctrl_model #(.PERIOD(PWM)) ctrl (.clk(CLK), .resetn(RESETN), .fb(FEEDBACK_PWM),
    .req(req), .done(done), .quarters(quarters));

  always #12.5 CLK = ~CLK;

  task check(input logic [32:0] seen, input logic [32:0] expv);
    checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task end_of_test;
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [32:0] expv);
    exp_rd.push_back(expv);
    apb(1'b0, a, 32'h0);
  endtask

  task measure(input logic [2:0] q);
    exp_duty.push_back(q);
    @(posedge CLK);
    req <= 1'b1;
    @(posedge CLK);
    req <= 1'b0;
    repeat (PWM + 3) @(posedge CLK);
  endtask

  task count_tog(input int n);
    logic last;
    last = STATUS_LED;
    t = 0;
    repeat (n) begin
      @(posedge CLK);
      if (STATUS_LED !== last) t++;
      last = STATUS_LED;
    end
  endtask

  function automatic logic [2:0] lvl(input logic [2:0] s, input logic j, input logic w);
    if (!j) return (w || s == 3'h0) ? 3'h0 : 3'h4;
    if (w) return 3'h1;
    case (s)
      3'h0: return 3'h0;
      3'h1: return 3'h2;
      3'h2: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction

  function automatic logic [32:0] stat(input logic [5:0] c, input logic w, input logic j,
                                       input logic b, input logic [2:0] s);
    return {19'h0, lvl(s, j, w), b && s != 3'h2, b, j, w, 1'b1, c};
  endfunction

  // answers are compared in the edge where they stand
  always @(posedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
      if (exp_rd.size() > 0) check({PSLVERR, PRDATA}, exp_rd.pop_front());
      else check(33'h1, 33'h0);
    end
    if (done === 1'b1) begin
      if (exp_duty.size() > 0) check(33'(quarters), 33'(exp_duty.pop_front()));
      else check(33'h1, 33'h0);
    end
  end

  always @(posedge CLK) begin
    cyc++;
    if (cyc > 6000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    CLK = 0;
    RESETN = 0;
    {PSEL, PENABLE, PWRITE, req} = 4'h0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    void'($urandom(89));
    code = 6'($urandom_range(62, 1));
    for (int k = 1; k <= 6; k++) begin
      SWITCH[k] = code[k-1];
    end
    FB_JUMPER = 1'b1;
    RANGE_BRIDGE = 1'b1;
    repeat (20) @(posedge CLK);
    check({FEEDBACK_PWM, IRQ, DISP_CODE}, {2'b00, DISP_RESET});
    RESETN <= 1'b1;
    repeat (24) @(posedge CLK);
    SWITCH <= ~code;
    check(DISP_CODE, {GLYPH_C, GLYPH_0, 4'(code / 10), 4'(code % 10)});
    repeat (60) @(posedge CLK);
    apb(1'b1, ADDR_DISP, 32'h1234);
    repeat (2) @(posedge CLK);
    check(DISP_CODE, 16'h1234);
    for (int j = 1; j >= 0; j--) begin
      FB_JUMPER <= j[0];
      RANGE_BRIDGE <= j[0];
      for (int s = 0; s < 5; s++) begin
        apb(1'b1, ADDR_CTRL, 32'(s));
        repeat (12) @(posedge CLK);
        measure(lvl(3'(s), j[0], 1'b0));
        rd(ADDR_STATUS, stat(code, 1'b0, j[0], j[0], 3'(s)));
        check(FULL_RANGE, j[0] && s != 2);
        count_tog(s == 0 ? 12 : 28);
        check(33'(t), s < 2 ? 33'h4 : 33'h0);
        if (s > 1) check(STATUS_LED, 1'b1);
      end
    end
    rd(ADDR_INT_STATUS, 33'h5);
    apb(1'b1, ADDR_INT_ENABLE, 32'h1);
    repeat (3) @(posedge CLK);
    check(IRQ, 1'b1);
    apb(1'b1, ADDR_INT_CLEAR, 32'h1);
    repeat (3) @(posedge CLK);
    check(IRQ, 1'b0);
    rd(ADDR_INT_STATUS, 33'h4);
    rd(ADDR_INT_ENABLE, 33'h1);
    apb(1'b1, ADDR_INT_ENABLE, 32'h4);
    apb(1'b1, ADDR_INT_CLEAR, 32'h4);
    repeat (3) @(posedge CLK);
    check(IRQ, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (12) @(posedge CLK);
    check(IRQ, 1'b1);
    rd(ADDR_INT_CLEAR, 33'h0);
    rd(8'h18, 33'h1_0000_0000);
    RESETN <= 1'b0;
    SWITCH <= 6'h00;
    FB_JUMPER <= 1'b1;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (30) @(posedge CLK);
    check(DISP_CODE, DISP_WRONG_CODE);
    measure(3'h1);
    SWITCH <= code;
    apb(1'b1, ADDR_CTRL, 32'h3);
    repeat (80) @(posedge CLK);
    check(DISP_CODE, DISP_WRONG_CODE);
    rd(ADDR_STATUS, stat(6'h00, 1'b1, 1'b1, 1'b0, 3'h3));
    rd(ADDR_INT_STATUS, 33'h7);
    measure(3'h1);
    count_tog(12);
    check(33'(t), 33'h4);
    FB_JUMPER <= 1'b0;
    repeat (12) @(posedge CLK);
    measure(3'h0);
    end_of_test();
  end
endmodule // testbench
